// [design/tfg_generator.sv]
/*
 * Ethernet test-frame generator with its AHB-Lite register slave and an
 * output FIFO toward the transmit path.
 * Assumes the transmit path sits on hclk and drains bytes with tx_ready.
 */
// Implementation choice: the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none

// ********************************************************************
// Output FIFO
// ********************************************************************
module tfg_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0] wr_q;
    logic [AW:0] rd_q;
    logic full;
    logic empty;

    // Pointers carry a wrap bit so full and empty are exact
    assign empty = (wr_q == rd_q);
    assign full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = mem_q[rd_q[AW-1:0]];

    // Write side
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_q <= '0;
        end else if (in_valid && !full) begin
            wr_q <= wr_q + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (in_valid && !full) begin
            mem_q[wr_q[AW-1:0]] <= in_data;
        end
    end

    // Read side
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_q <= '0;
        end else if (out_ready && !empty) begin
            rd_q <= rd_q + 1'b1;
        end
    end
endmodule : tfg_fifo

// ********************************************************************
// Generator top
// ********************************************************************
module tfg_generator
    import tfg_pkg::*;
#(
    parameter int BURST_FRAMES = 30000000,
    parameter int BLOCK_FRAMES = 10000,
    parameter int FIFO_DEPTH = 8
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic [7:0] tx_data,
    output logic tx_first,
    output logic tx_last,
    output logic tx_valid,
    input wire logic tx_ready
);
    logic [15:0] ctrl_q;
    logic [15:0] pat_q;
    logic [31:0] hrdata_q;
    logic wr_pend_q;
    logic [7:0] wr_idx_q;
    logic go;
    logic go_q;
    logic start_pend_q;
    logic start;
    tfg_state_t state_q;
    logic [13:0] idx_q;
    logic [10:0] gap_q;
    logic [24:0] frames_q;
    logic [13:0] blk_q;
    logic [31:0] crc_q;
    logic [15:0] lfsr_q;
    logic [1:0] len_lat_q;
    logic gap_lat_q;
    logic [3:0] da_lat_q;
    logic [3:0] sa_lat_q;
    logic rand_lat_q;
    logic bad_lat_q;
    logic cont_lat_q;
    logic [15:0] pat_lat_q;
    logic [13:0] len;
    logic [13:0] fcs_at;
    logic [15:0] plen;
    logic [7:0] byte_d;
    logic [31:0] fcs;
    logic [1:0] fcs_sel;
    logic push;
    logic push_ready;
    logic last;
    logic fe;
    logic stop_burst;
    logic stop_cont;
    logic addr_ok;

    // ****************************************************************
    // AHB-Lite slave, zero wait states, always OKAY
    // ****************************************************************
    assign addr_ok = hsel && hready && htrans[1];
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;

    // Address phase capture for writes, read data loaded for the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_idx_q <= 8'h00;
            hrdata_q <= 32'h00000000;
        end else begin
            wr_pend_q <= addr_ok && hwrite && (haddr[1:0] == 2'b00) && (hsize == 3'b010);
            wr_idx_q <= haddr[9:2];
            if (addr_ok && !hwrite) begin
                case (haddr[9:2])
                    TFG_CTRL_IDX: hrdata_q <= {16'h0000, ctrl_q};
                    TFG_PAT_IDX: hrdata_q <= {16'h0000, pat_q};
                    TFG_STAT_IDX: hrdata_q <= {frames_q[15:0], 14'h0000,
                        state_q == S_DONE, state_q == S_FRAME || state_q == S_GAP};
                    default: hrdata_q <= 32'h00000000;
                endcase
            end
        end
    end

    // Control and pattern registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q <= TFG_CTRL_RST;
            pat_q <= TFG_PAT_RST;
        end else if (wr_pend_q) begin
            if (wr_idx_q == TFG_CTRL_IDX) begin
                ctrl_q <= hwdata[15:0];
            end
            if (wr_idx_q == TFG_PAT_IDX) begin
                pat_q <= hwdata[15:0];
            end
        end
    end

    // ****************************************************************
    // Run control: a rising enable-and-run arms one restart
    // ****************************************************************
    assign go = ctrl_q[TFG_EN_BIT] && ctrl_q[TFG_RUN_BIT];
    assign start = go && start_pend_q && (state_q == S_IDLE || state_q == S_DONE);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            go_q <= 1'b0;
            start_pend_q <= 1'b0;
        end else begin
            go_q <= go;
            if (!go || start) begin
                start_pend_q <= 1'b0;
            end else if (!go_q) begin
                start_pend_q <= 1'b1;
            end
        end
    end

    // Settings held for the whole run
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            len_lat_q <= 2'b00;
            gap_lat_q <= 1'b0;
            da_lat_q <= 4'h0;
            sa_lat_q <= 4'h0;
            rand_lat_q <= 1'b0;
            bad_lat_q <= 1'b0;
            cont_lat_q <= 1'b0;
            pat_lat_q <= 16'h0000;
        end else if (start) begin
            len_lat_q <= ctrl_q[TFG_LEN_HI:TFG_LEN_LO];
            gap_lat_q <= ctrl_q[TFG_GAP_BIT];
            da_lat_q <= ctrl_q[TFG_DA_HI:TFG_DA_LO];
            sa_lat_q <= ctrl_q[TFG_SA_HI:TFG_SA_LO];
            rand_lat_q <= ctrl_q[TFG_RAND_BIT];
            bad_lat_q <= ctrl_q[TFG_BAD_BIT];
            cont_lat_q <= ctrl_q[TFG_CONT_BIT];
            pat_lat_q <= pat_q;
        end
    end

    // ****************************************************************
    // Frame byte builder
    // ****************************************************************
    assign len = tfg_frame_len(len_lat_q);
    assign fcs_at = len - TFG_FCS_BYTES;
    assign plen = {2'b00, fcs_at - TFG_HDR_BYTES};
    assign fcs = bad_lat_q ? crc_q : ~crc_q;
    assign fcs_sel = idx_q[1:0] - fcs_at[1:0]; // Two bits, so the byte select wraps within the word
    assign push = (state_q == S_FRAME);
    assign last = (idx_q == len - 14'h0001);
    assign fe = push && push_ready && last;

    // Byte for the current position
    always_comb begin
        byte_d = 8'hFF;
        if (idx_q == 14'h0005) begin
            byte_d = {4'hF, da_lat_q};
        end else if (idx_q == 14'h000B) begin
            byte_d = {4'hF, sa_lat_q};
        end else if (idx_q == 14'h000C) begin
            byte_d = plen[15:8];
        end else if (idx_q == 14'h000D) begin
            byte_d = plen[7:0];
        end else if (idx_q >= fcs_at) begin
            byte_d = fcs[8*fcs_sel +: 8];
        end else if (idx_q >= TFG_HDR_BYTES) begin
            if (rand_lat_q) begin
                byte_d = lfsr_q[7:0];
            end else begin
                byte_d = idx_q[0] ? pat_lat_q[7:0] : pat_lat_q[15:8];
            end
        end
    end

    // Running CRC over all bytes before the check sequence
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            crc_q <= 32'hFFFFFFFF;
        end else if (push && push_ready) begin
            crc_q <= (idx_q < fcs_at) ? tfg_crc_byte(crc_q, byte_d) : crc_q;
            if (last) begin
                crc_q <= 32'hFFFFFFFF;
            end
        end
    end

    // Payload scrambler, one step per byte
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lfsr_q <= TFG_LFSR_SEED;
        end else if (push && push_ready) begin
            lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
        end
    end

    // ****************************************************************
    // Sequencer: frame, gap, stop decisions
    // ****************************************************************
    assign stop_burst = !cont_lat_q && (frames_q == 25'(BURST_FRAMES - 1));
    assign stop_cont = cont_lat_q && !ctrl_q[TFG_CONT_BIT]
        && (blk_q == 14'(BLOCK_FRAMES - 1));

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= S_IDLE;
            idx_q <= 14'h0000;
            gap_q <= 11'h000;
        end else begin
            case (state_q)
                S_IDLE, S_DONE: begin
                    if (start) begin
                        state_q <= S_FRAME;
                        idx_q <= 14'h0000;
                    end else if (!go) begin
                        state_q <= S_IDLE;
                    end
                end
                S_FRAME: begin
                    if (push_ready) begin
                        idx_q <= idx_q + 14'h0001;
                        if (last) begin
                            idx_q <= 14'h0000;
                            gap_q <= (gap_lat_q ? TFG_GAP_LONG_CYC : TFG_GAP_SHORT_CYC)
                                - 11'h001;
                            if (!go) begin
                                state_q <= S_IDLE;
                            end else if (stop_burst || stop_cont) begin
                                state_q <= S_DONE;
                            end else begin
                                state_q <= S_GAP;
                            end
                        end
                    end
                end
                S_GAP: begin
                    gap_q <= gap_q - 11'h001;
                    if (!go) begin
                        state_q <= S_IDLE;
                    end else if (gap_q == 11'h000) begin
                        state_q <= S_FRAME;
                    end
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end

    // Frame counters, cleared at each start
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            frames_q <= 25'h0000000;
            blk_q <= 14'h0000;
        end else if (start) begin
            frames_q <= 25'h0000000;
            blk_q <= 14'h0000;
        end else if (fe) begin
            frames_q <= frames_q + 25'h0000001;
            blk_q <= (blk_q == 14'(BLOCK_FRAMES - 1)) ? 14'h0000 : blk_q + 14'h0001;
        end
    end

    // ****************************************************************
    // Output buffer
    // ****************************************************************
    tfg_fifo #(
        .WIDTH(10),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(hclk),
        .rst_n(hresetn),
        .in_valid(push),
        .in_ready(push_ready),
        .in_data({idx_q == 14'h0000, last, byte_d}),
        .out_valid(tx_valid),
        .out_ready(tx_ready),
        .out_data({tx_first, tx_last, tx_data})
    );

    // ****************************************************************
    // Checks
    // ****************************************************************
    a_start_needs_go: assert property (@(posedge hclk) disable iff (!hresetn)
        (state_q == S_FRAME && $past(state_q) != S_FRAME && $past(state_q) != S_GAP)
        |-> $past(go)) else $error("frame started without enable and run");
    a_cont_keeps_on: assert property (@(posedge hclk) disable iff (!hresetn)
        (fe && go && cont_lat_q && ctrl_q[TFG_CONT_BIT]) |=> state_q == S_GAP)
        else $error("continuous run stopped");
    a_burst_stops: assert property (@(posedge hclk) disable iff (!hresetn)
        (fe && go && !cont_lat_q && frames_q == 25'(BURST_FRAMES - 1))
        |=> state_q == S_DONE && frames_q == 25'(BURST_FRAMES)) else $error("burst end missed");
    a_block_stop: assert property (@(posedge hclk) disable iff (!hresetn)
        (fe && go && stop_cont) |=> state_q == S_DONE && blk_q == 14'h0000)
        else $error("block boundary stop missed");
    a_frame_size: assert property (@(posedge hclk) disable iff (!hresetn)
        fe |-> idx_q + 14'h0001 == tfg_frame_len(len_lat_q)) else $error("wrong frame size");
    a_gap_length: assert property (@(posedge hclk) disable iff (!hresetn)
        (state_q == S_GAP && $past(state_q) == S_FRAME)
        |-> gap_q == (gap_lat_q ? TFG_GAP_LONG_CYC : TFG_GAP_SHORT_CYC) - 11'h001)
        else $error("wrong gap length");
    a_dest_nibble: assert property (@(posedge hclk) disable iff (!hresetn)
        (push && idx_q == 14'h0005) |-> byte_d == {4'hF, da_lat_q})
        else $error("destination nibble wrong");
    a_src_nibble: assert property (@(posedge hclk) disable iff (!hresetn)
        (push && idx_q == 14'h000B) |-> byte_d == {4'hF, sa_lat_q})
        else $error("source nibble wrong");
    a_fixed_pattern: assert property (@(posedge hclk) disable iff (!hresetn)
        (push && !rand_lat_q && idx_q == TFG_HDR_BYTES) |-> byte_d == pat_lat_q[15:8])
        else $error("pattern byte wrong");
    a_fcs_sense: assert property (@(posedge hclk) disable iff (!hresetn)
        fe |-> byte_d == (bad_lat_q ? crc_q[31:24] : ~crc_q[31:24]))
        else $error("check sequence sense wrong");
    a_start_clears: assert property (@(posedge hclk) disable iff (!hresetn)
        start |=> frames_q == 25'h0000000 && len_lat_q == $past(ctrl_q[12:11]))
        else $error("restart did not clear and latch");
endmodule : tfg_generator

`default_nettype wire

// [design/tfg_pkg.sv]
/*
 * Constants for the Ethernet test-frame generator: register indices, field
 * positions, reset values, frame sizes and gap lengths.
 * Assumes a 25 MHz system clock and one generated byte slot per clock.
 */
// Functional notes
// - A frame starts only while enable and run are both one and is always sent to its end; both reset zero.
// - Continuous mode sends frames without end, counted in blocks of ten thousand.
// - Burst mode sends thirty million frames, then stops by itself.
// - Clearing continuous mid-run stops at the next ten-thousand-frame boundary.
// - Length code 00/01/10/11 gives 125, 64, 1518 or 10000-byte frames.
// - Idle gap between frames is 96 bit times, or 8192 when gap bit set.
// - Destination address is all ones with low nibble from bits 9:6, reset 0001.
// - Source address is all ones with low nibble from bits 5:2, reset 0000.
// - Payload type one gives random payload; zero gives the fixed pattern.
// - Bad-checksum bit one corrupts each frame check sequence; zero keeps it correct.
// - Fixed payload repeats the sixteen-bit pattern register, which resets to zero.
package tfg_pkg;
    // ****************************************************************
    // Register map, word index times four gives the byte address
    // ****************************************************************
    localparam logic [7:0] TFG_CTRL_IDX = 8'h1D;
    localparam logic [7:0] TFG_PAT_IDX = 8'h1E;
    localparam logic [7:0] TFG_STAT_IDX = 8'h1F;
    localparam logic [15:0] TFG_CTRL_RST = 16'h0040;
    localparam logic [15:0] TFG_PAT_RST = 16'h0000;

    // ****************************************************************
    // Control field positions
    // ****************************************************************
    localparam int TFG_EN_BIT = 15;
    localparam int TFG_RUN_BIT = 14;
    localparam int TFG_CONT_BIT = 13;
    localparam int TFG_LEN_HI = 12;
    localparam int TFG_LEN_LO = 11;
    localparam int TFG_GAP_BIT = 10;
    localparam int TFG_DA_HI = 9;
    localparam int TFG_DA_LO = 6;
    localparam int TFG_SA_HI = 5;
    localparam int TFG_SA_LO = 2;
    localparam int TFG_RAND_BIT = 1;
    localparam int TFG_BAD_BIT = 0;
    localparam int TFG_STAT_BUSY = 0;
    localparam int TFG_STAT_DONE = 1;

    // ****************************************************************
    // Frame layout and timing
    // ****************************************************************
    localparam logic [13:0] TFG_LEN_125 = 14'h007D;
    localparam logic [13:0] TFG_LEN_64 = 14'h0040;
    localparam logic [13:0] TFG_LEN_1518 = 14'h05EE;
    localparam logic [13:0] TFG_LEN_JUMBO = 14'h2710;
    localparam logic [13:0] TFG_HDR_BYTES = 14'h000E;
    localparam logic [13:0] TFG_FCS_BYTES = 14'h0004;
    localparam int TFG_BITS_PER_BYTE = 8;
    localparam int TFG_GAP_SHORT_BITS = 96;
    localparam int TFG_GAP_LONG_BITS = 8192;
    localparam logic [10:0] TFG_GAP_SHORT_CYC = 11'(TFG_GAP_SHORT_BITS / TFG_BITS_PER_BYTE);
    localparam logic [10:0] TFG_GAP_LONG_CYC = 11'(TFG_GAP_LONG_BITS / TFG_BITS_PER_BYTE);
    localparam logic [31:0] TFG_CRC_POLY = 32'hEDB88320;
    localparam logic [15:0] TFG_LFSR_SEED = 16'hACE1;

    typedef enum logic [1:0] {S_IDLE, S_FRAME, S_GAP, S_DONE} tfg_state_t;

    // Frame size in bytes for a length code
    function automatic logic [13:0] tfg_frame_len(input logic [1:0] code);
        case (code)
            2'b00: return TFG_LEN_125;
            2'b01: return TFG_LEN_64;
            2'b10: return TFG_LEN_1518;
            default: return TFG_LEN_JUMBO;
        endcase
    endfunction : tfg_frame_len

    // One byte of reflected CRC-32
    function automatic logic [31:0] tfg_crc_byte(input logic [31:0] c, input logic [7:0] d);
        logic [31:0] r;
        r = c ^ {24'h000000, d};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ TFG_CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction : tfg_crc_byte
endpackage : tfg_pkg

// [test/tb_top.sv]
/*
 * Self-checking bench for the test-frame generator over AHB-Lite.
 * Assumes tfg_pkg and the drain model tfg_tx_sink are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Bench top
// ****************************************************************
module tb_top
    import tfg_pkg::*;
;
    localparam logic [31:0] A_CTRL = 32'h0000_0074;
    localparam logic [31:0] A_PAT = 32'h0000_0078;
    logic hclk, hresetn, hsel, hwrite, stall, hreadyout, hresp;
    logic tx_first, tx_last, tx_valid, tx_ready;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [7:0] tx_data;
    logic [31:0] haddr, hwdata, hrdata, d;
    int num_errors, check_count, cyc, f;
    int lens [4] = '{125, 64, 1518, 10000};

    tfg_generator #(.BURST_FRAMES(5), .BLOCK_FRAMES(3), .FIFO_DEPTH(8)) u_dut (.hclk(hclk),
        .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .tx_data(tx_data), .tx_first(tx_first),
        .tx_last(tx_last), .tx_valid(tx_valid), .tx_ready(tx_ready));
    // A local drain stands at the far end, so no live network ever sees frames
    tfg_tx_sink u_sink (.hclk(hclk), .hresetn(hresetn), .stall(stall), .tx_data(tx_data),
        .tx_first(tx_first), .tx_last(tx_last), .tx_valid(tx_valid), .tx_ready(tx_ready));

    // Clock and hang guard
    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 70000) begin
            num_errors++;
            end_sim();
        end
    end

    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_sim

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    // Single AHB-Lite transfer; hrdata taken at the closing edge
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'b10;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        d = hrdata;
    endtask : ahb

    task automatic wait_frames(input int n);
        int t;
        t = 0;
        while (u_sink.frames < n && t < 20000) begin
            @(posedge hclk);
            t++;
        end
        check("frames", 32'(u_sink.frames), 32'(n));
    endtask : wait_frames

    function automatic logic [31:0] ctl(input logic c, input logic [1:0] l, input logic g,
        input logic [3:0] da, input logic [3:0] sa, input logic r, input logic b);
        return {16'h0000, 2'b11, c, l, g, da, sa, r, b};
    endfunction : ctl

    // Compare the stored frame with its layout, payload and check sequence
    task automatic chk_frame(input int len, input logic [3:0] da, input logic [3:0] sa,
        input logic [15:0] pat, input logic rnd, input logic bad);
        logic [111:0] hdr;
        logic [31:0] c;
        int diff;
        hdr = {40'hFFFFFFFFFF, 4'hF, da, 40'hFFFFFFFFFF, 4'hF, sa, 16'(len - 18)};
        diff = 0;
        c = 32'hFFFFFFFF;
        check("len", 32'(u_sink.last_len), 32'(len));
        for (int i = 0; i < len - 4; i++) begin
            if (i < 14) begin
                check("hdr", 32'(u_sink.fr[i]), 32'(hdr[111 - 8 * i -: 8]));
            end else if (!rnd) begin
                check("pay", 32'(u_sink.fr[i]), 32'(i % 2 ? pat[7:0] : pat[15:8]));
            end else begin
                diff += (u_sink.fr[i] !== (i % 2 ? pat[7:0] : pat[15:8]));
            end
            c = c ^ {24'h000000, u_sink.fr[i]};
            for (int b = 0; b < 8; b++) begin
                c = c[0] ? ((c >> 1) ^ 32'hEDB88320) : (c >> 1);
            end
        end
        check("rnd", 32'(diff > 0), 32'(rnd));
        check("fcs", {u_sink.fr[len-1], u_sink.fr[len-2], u_sink.fr[len-3], u_sink.fr[len-4]},
            bad ? c : ~c);
    endtask : chk_frame

    // Main sequence
    initial begin
        {hsel, hwrite, htrans, haddr, hwdata, stall, hresetn} = '0;
        hsize = 3'b010;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        ahb(1'b0, A_CTRL, 0);
        check("ctrl_rst", d, 32'h0000_0040);
        ahb(1'b0, A_PAT, 0);
        check("pat_rst", d, 32'h0000_0000);
        ahb(1'b1, 32'h0000_0010, 32'h0000_FFFF);
        ahb(1'b0, 32'h0000_0010, 0);
        check("unmapped", d, 32'h0000_0000);
        check("hresp", 32'(hresp), 32'h0000_0000);
        ahb(1'b1, A_CTRL, 32'h0000_8040);
        repeat (60) @(posedge hclk);
        ahb(1'b1, A_CTRL, 32'h0000_4040);
        repeat (60) @(posedge hclk);
        check("half_on", 32'(u_sink.idx), 32'h0000_0000);
        $display("test reset and enable done");
        for (int k = 0; k < 4; k++) begin
            f = u_sink.frames;
            ahb(1'b1, A_CTRL, ctl(1'b0, 2'(k), 1'b0, 4'h1, 4'h0, 1'b0, 1'b0));
            wait_frames(f + 1);
            ahb(1'b1, A_CTRL, 0);
            repeat (40) @(posedge hclk);
            check("run_off", 32'(u_sink.frames), 32'(f + 1));
            chk_frame(lens[k], 4'h1, 4'h0, 16'h0000, 1'b0, 1'b0);
        end
        $display("test lengths done");
        stall <= 1'b1;
        ahb(1'b1, A_PAT, 32'h0000_1234);
        f = u_sink.frames;
        ahb(1'b1, A_CTRL, ctl(1'b0, 2'b01, 1'b0, 4'hA, 4'h5, 1'b0, 1'b0));
        wait_frames(f + 1);
        ahb(1'b1, A_PAT, 32'h0000_BEEF);
        wait_frames(f + 5);
        repeat (300) @(posedge hclk);
        check("burst", 32'(u_sink.frames), 32'(f + 5));
        ahb(1'b0, 32'h0000_007C, 0);
        check("status", d, 32'h0005_0002);
        chk_frame(64, 4'hA, 4'h5, 16'h1234, 1'b0, 1'b0);
        ahb(1'b1, A_CTRL, 0);
        f = u_sink.frames;
        ahb(1'b1, A_CTRL, ctl(1'b0, 2'b01, 1'b0, 4'h3, 4'hC, 1'b0, 1'b1));
        wait_frames(f + 5);
        repeat (300) @(posedge hclk);
        check("restart", 32'(u_sink.frames), 32'(f + 5));
        chk_frame(64, 4'h3, 4'hC, 16'hBEEF, 1'b0, 1'b1);
        $display("test burst done");
        stall <= 1'b0;
        ahb(1'b1, A_CTRL, 0);
        f = u_sink.frames;
        ahb(1'b1, A_CTRL, ctl(1'b1, 2'b01, 1'b0, 4'h1, 4'h0, 1'b1, 1'b0));
        wait_frames(f + 4);
        ahb(1'b1, A_CTRL, ctl(1'b0, 2'b01, 1'b0, 4'h1, 4'h0, 1'b1, 1'b0));
        wait_frames(f + 6);
        check("gap_s", 32'(u_sink.gap >= 10 && u_sink.gap <= 14), 32'h1);
        repeat (300) @(posedge hclk);
        check("cont", 32'(u_sink.frames), 32'(f + 6));
        chk_frame(64, 4'h1, 4'h0, 16'hBEEF, 1'b1, 1'b0);
        ahb(1'b1, A_CTRL, 0);
        f = u_sink.frames;
        ahb(1'b1, A_CTRL, ctl(1'b1, 2'b01, 1'b1, 4'h1, 4'h0, 1'b0, 1'b0));
        wait_frames(f + 2);
        check("gap_l", 32'(u_sink.gap >= 1022 && u_sink.gap <= 1026), 32'h1);
        ahb(1'b1, A_CTRL, 0);
        $display("test continuous and gap done");
        end_sim();
    end
endmodule : tb_top
`default_nettype wire

// [test/tfg_tx_sink.sv]
/*
 * Drain model on the transmit side of the test-frame generator.
 * Assumes the hclk domain; the bench drives stall to throttle acceptance.
 */
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Transmit drain
// ****************************************************************
module tfg_tx_sink (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic stall,
    input wire logic [7:0] tx_data,
    input wire logic tx_first,
    input wire logic tx_last,
    input wire logic tx_valid,
    output logic tx_ready
);
    logic [7:0] fr [0:10015];
    int frames, last_len, gap, idx, idle;
    logic ph_q;

    // Half-rate acceptance while stalled, so the FIFO fills and refuses
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_q <= 1'b0;
            tx_ready <= 1'b1;
        end else begin
            ph_q <= ~ph_q;
            tx_ready <= ~stall | ph_q;
        end
    end

    // Store the frame, count frames and idle cycles between them
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            frames <= 0;
            idx <= 0;
            idle <= 0;
            last_len <= 0;
            gap <= 0;
        end else if (tx_valid && tx_ready) begin
            fr[tx_first ? 0 : idx] <= tx_data;
            idx <= tx_first ? 1 : idx + 1;
            if (tx_first) begin
                gap <= idle;
            end
            if (tx_last) begin
                frames <= frames + 1;
                last_len <= tx_first ? 1 : idx + 1;
                idle <= 0;
            end
        end else begin
            idle <= idle + 1;
        end
    end
endmodule : tfg_tx_sink
`default_nettype wire
